//--- logic/pdcs_map.vh
// Behaviour
// RQ1 - Below lower lockout: sequencer reset, node open
// RQ2 - Above turn-on: switch on at inrush limit
// RQ3 - Current settled 150 us: operational limit, release flag
// RQ4 - Lockout while powered: switch off, reset
// RQ5 - Soft overload keeps operational limit selected
// RQ6 - Thermal shutdown: switch off, flag low
// RQ7 - Cool restart below 10 V: operational, flag released; code restarts at inrush when thermal was entered from idle or inrush
// RQ8 - Above 10 V while off: restart at inrush
// RQ9 - Hard overload 150 us: inrush limit, flag low
// RQ10 - Input step above 10 V: back to inrush
// RQ11 - Never latch off; always retry automatically
// RQ12 - Flag pulled low when off, inrush, high voltage; code leaves it open when off in detection and idle
// RQ13 - Hot die disables switch and class sink
// RQ14 - Thermal checked outside detection, keeps cycling
// RQ15 - Converter should wait for power good
// RQ16 - Below class threshold: detection, everything open
// RQ17 - Inputs synchronised, debounced; intervals counted
// RQ18 - Qualification counters restart when condition drops
`ifndef PDCS_MAP_VH
`define PDCS_MAP_VH
`define PDCS_CLK_HZ       25000000
`define PDCS_QUAL_NS      150000
`define PDCS_QUAL_CYC     ((`PDCS_QUAL_NS * (`PDCS_CLK_HZ / 1000000)) / 1000)
`define PDCS_DEB_CYC      4
`define PDCS_CNT_W        13
`define PDCS_ST_DETECT    3'h0
`define PDCS_ST_IDLE      3'h1
`define PDCS_ST_INRUSH    3'h2
`define PDCS_ST_RUN       3'h3
`define PDCS_ST_THERMAL   3'h4
`endif

//--- logic/pdcs_debounce.v
`timescale 1ns/1ps
`include "pdcs_map.vh"
module pdcs_debounce #(
  parameter DEB = `PDCS_DEB_CYC
) (
  // Clock and reset
  input  wire clk_sys,
  input  wire rst_n,
  // Raw and filtered level
  input  wire din,
  output reg  dout_r
);
  reg       s1_r;
  reg       s2_r;
  reg [3:0] cnt_r;
  // RQ17 two-stage sync, stability count
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      cnt_r  <= 4'h0;
      dout_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      if (s2_r == dout_r) begin
        cnt_r <= 4'h0;
      end else if (cnt_r == DEB[3:0] - 4'h1) begin
        cnt_r  <= 4'h0;
        dout_r <= s2_r;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule

//--- logic/pdcs_sequencer.v
`timescale 1ns/1ps
`include "pdcs_map.vh"
module pdcs_sequencer #(
  parameter QUAL_CYC = `PDCS_QUAL_CYC
) (
  // Clock and reset
  input  wire clk_sys,
  input  wire rst_n,
  // Comparator levels
  input  wire above_class_low,
  input  wire undervoltage_lockout,
  input  wire uv_turn_on,
  input  wire inrush_limit_program_active,
  input  wire inrush_settled,
  input  wire vsw_above_10v,
  input  wire over_temp,
  // Switch and limit control
  output reg  switch_on_r,
  output reg  inrush_limit_program_r,
  output reg  class_sink_en_r,
  output reg  detection_sink_r,
  // Power good, open drain, oe low drives low
  output reg  power_good_flag_oe_n_r,
  output reg  power_good_flag_o_r
);
  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  wire cls_q;
  wire uvl_q;
  wire uvon_q;
  wire lim_q;
  wire set_q;
  wire hv_q;
  wire ot_q;
  // RQ17 every comparator filtered
  // Same filter on all inputs keeps their relative timing intact
  pdcs_debounce u_cls (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (above_class_low),
    .dout_r  (cls_q)
  );
  pdcs_debounce u_uvl (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (undervoltage_lockout),
    .dout_r  (uvl_q)
  );
  pdcs_debounce u_uvon (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (uv_turn_on),
    .dout_r  (uvon_q)
  );
  pdcs_debounce u_lim (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (inrush_limit_program_active),
    .dout_r  (lim_q)
  );
  pdcs_debounce u_set (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (inrush_settled),
    .dout_r  (set_q)
  );
  pdcs_debounce u_hv (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (vsw_above_10v),
    .dout_r  (hv_q)
  );
  pdcs_debounce u_ot (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (over_temp),
    .dout_r  (ot_q)
  );

  // ----------------------------------------
  // State and counters
  // ----------------------------------------
  reg [2:0]             st_r;
  reg [2:0]             st_nxt;
  reg [`PDCS_CNT_W-1:0] qual_r;
  reg [`PDCS_CNT_W-1:0] qual_nxt;
  reg                   hv_seen_r;
  reg                   hv_seen_nxt;
  reg                   qual_cond;
  wire                  qual_done;
  assign qual_done = (qual_r == QUAL_CYC[`PDCS_CNT_W-1:0] - 1'b1);

  always @* begin
    st_nxt      = st_r;
    hv_seen_nxt = hv_seen_r;
    qual_cond   = 1'b0;
    case (st_r)
      `PDCS_ST_DETECT: begin
        // RQ16 stay in detection
        if (cls_q) begin
          st_nxt = `PDCS_ST_IDLE;
        end
      end
      `PDCS_ST_IDLE: begin
        // RQ1 held in reset below lockout
        if (!cls_q) begin
          st_nxt = `PDCS_ST_DETECT;
        end else if (ot_q) begin
          // RQ14 thermal outside detection
          st_nxt      = `PDCS_ST_THERMAL;
          hv_seen_nxt = 1'b1;
        end else if (uvon_q && !uvl_q) begin
          // RQ2 switch on at inrush
          st_nxt = `PDCS_ST_INRUSH;
        end
      end
      `PDCS_ST_INRUSH: begin
        qual_cond = set_q;
        if (uvl_q || !cls_q) begin
          // RQ4 lockout resets sequencer
          st_nxt = `PDCS_ST_IDLE;
        end else if (ot_q) begin
          // RQ13 hot die shuts switch
          st_nxt      = `PDCS_ST_THERMAL;
          hv_seen_nxt = 1'b1;
        end else if (set_q && qual_done) begin
          // RQ3 settled long enough
          st_nxt = `PDCS_ST_RUN;
        end
      end
      `PDCS_ST_RUN: begin
        // RQ5 soft overload stays here
        qual_cond = lim_q && hv_q;
        if (uvl_q || !cls_q) begin
          // RQ4 lockout resets sequencer
          st_nxt = `PDCS_ST_IDLE;
        end else if (ot_q) begin
          // RQ6 thermal shutdown
          st_nxt      = `PDCS_ST_THERMAL;
          hv_seen_nxt = 1'b0;
        end else if (qual_cond && qual_done) begin
          // RQ9 RQ10 hard overload or step
          st_nxt = `PDCS_ST_INRUSH;
        end
      end
      `PDCS_ST_THERMAL: begin
        if (hv_q) begin
          hv_seen_nxt = 1'b1;
        end
        if (uvl_q || !cls_q) begin
          st_nxt = `PDCS_ST_IDLE;
        end else if (!ot_q) begin
          // RQ11 automatic retry, RQ7 RQ8
          if (hv_seen_r || hv_q) begin
            st_nxt = `PDCS_ST_INRUSH;
          end else begin
            st_nxt = `PDCS_ST_RUN;
          end
        end
      end
      default: begin
        st_nxt = `PDCS_ST_DETECT;
      end
    endcase
    // RQ18 restart when condition drops
    if (!qual_cond || st_nxt != st_r || qual_done) begin
      qual_nxt = {`PDCS_CNT_W{1'b0}};
    end else begin
      qual_nxt = qual_r + 1'b1;
    end
  end

  // ----------------------------------------
  // Output next values
  // ----------------------------------------
  // Decoded from the next state so pins move with the state register
  reg switch_on_nxt;
  reg inrush_limit_program_nxt;
  reg class_sink_en_nxt;
  reg detection_sink_nxt;
  reg power_good_flag_oe_n_nxt;
  reg power_good_flag_o_nxt;

  always @* begin
    // Safe defaults: switch off, inrush limit, flag open
    switch_on_nxt            = 1'b0;
    inrush_limit_program_nxt = 1'b1;
    class_sink_en_nxt        = 1'b0;
    detection_sink_nxt       = 1'b0;
    power_good_flag_oe_n_nxt = 1'b1;
    power_good_flag_o_nxt    = 1'b0;
    case (st_nxt)
      `PDCS_ST_DETECT: begin
        // RQ16 only detection sink active
        detection_sink_nxt = 1'b1;
      end
      `PDCS_ST_IDLE: begin
        // RQ13 class sink off when hot
        class_sink_en_nxt = !ot_q;
      end
      `PDCS_ST_INRUSH: begin
        // RQ12 flag low at inrush
        switch_on_nxt            = 1'b1;
        power_good_flag_oe_n_nxt = 1'b0;
      end
      `PDCS_ST_RUN: begin
        switch_on_nxt            = 1'b1;
        inrush_limit_program_nxt = 1'b0;
        // RQ12 flag low above 10 V
        // Follows the filtered level, so short spikes leave it open
        power_good_flag_oe_n_nxt = !hv_q;
      end
      `PDCS_ST_THERMAL: begin
        // RQ6 switch off, flag low
        power_good_flag_oe_n_nxt = 1'b0;
      end
      default: begin
        detection_sink_nxt = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Registers and outputs
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r                   <= `PDCS_ST_DETECT;
      qual_r                 <= {`PDCS_CNT_W{1'b0}};
      hv_seen_r              <= 1'b0;
      switch_on_r            <= 1'b0;
      inrush_limit_program_r <= 1'b1;
      class_sink_en_r        <= 1'b0;
      detection_sink_r       <= 1'b1;
      power_good_flag_oe_n_r <= 1'b1;
      power_good_flag_o_r    <= 1'b0;
    end else begin
      st_r                   <= st_nxt;
      qual_r                 <= qual_nxt;
      hv_seen_r              <= hv_seen_nxt;
      switch_on_r            <= switch_on_nxt;
      inrush_limit_program_r <= inrush_limit_program_nxt;
      class_sink_en_r        <= class_sink_en_nxt;
      detection_sink_r       <= detection_sink_nxt;
      power_good_flag_oe_n_r <= power_good_flag_oe_n_nxt;
      power_good_flag_o_r    <= power_good_flag_o_nxt;
    end
  end
endmodule

//--- sim/pdcs_monitor.sv
`timescale 1ns/1ps
module pdcs_monitor #(
  parameter QUAL_CYC = 20
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Comparators
  input wire above_class_low,
  input wire undervoltage_lockout,
  input wire inrush_limit_program_active,
  input wire inrush_settled,
  input wire vsw_above_10v,
  input wire over_temp,
  // Outputs
  input wire switch_on_r,
  input wire inrush_limit_program_r,
  input wire class_sink_en_r,
  input wire detection_sink_r,
  input wire power_good_flag_oe_n_r,
  input wire power_good_flag_o_r
);
  // -----------------
  // Qualifying runs
  // -----------------
  // Raw inputs lead the synchronised ones, so raw runs are shorter only when a glitch under the debounce count breaks them
  int set_c;
  int hv_c;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      set_c <= 0;
      hv_c <= 0;
    end else begin
      set_c <= inrush_settled ? set_c + 1 : 0;
      hv_c <= (inrush_limit_program_active && vsw_above_10v) ? hv_c + 1 : 0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence hot_s;
    over_temp[*8];
  endsequence
  pg_inrush_low_a: assert property (switch_on_r && inrush_limit_program_r
    |-> !power_good_flag_oe_n_r) else $error("flag open at inrush");
  pg_drive_zero_a: assert property (!power_good_flag_o_r)
    else $error("flag drive value not low");
  lockout_off_a: assert property (undervoltage_lockout[*8]
    |-> ##[0:4] !switch_on_r) else $error("switch on in lockout");
  detect_open_a: assert property (!above_class_low[*8] |-> ##[0:4]
    (detection_sink_r && !switch_on_r && power_good_flag_oe_n_r))
    else $error("detection state not entered");
  hot_off_a: assert property (hot_s
    |-> ##[0:4] (!switch_on_r && !class_sink_en_r)) else $error("hot die on");
  settle_qual_a: assert property ($fell(inrush_limit_program_r)
    |-> set_c >= QUAL_CYC) else $error("settle interval short");
  hard_qual_a: assert property ($rose(inrush_limit_program_r)
    && $stable(switch_on_r) && switch_on_r |-> hv_c >= QUAL_CYC)
    else $error("hard overload interval short");
  soft_keep_a: assert property ((switch_on_r && !inrush_limit_program_r
    && inrush_limit_program_active && !vsw_above_10v && !over_temp)[*8]
    |=> (!switch_on_r || !inrush_limit_program_r))
    else $error("soft overload left run");
endmodule

//--- sim/pdcs_far_model.sv
`timescale 1ns/1ps
module pdcs_far_model (
  // Flag pin from the block
  input  wire power_good_flag_oe_n_r,
  input  wire power_good_flag_o_r,
  // Line level and converter enable
  output wire pg_line,
  output wire conv_en
);
  // Pull-up holds the released line high
  assign pg_line = power_good_flag_oe_n_r ? 1'b1 : power_good_flag_o_r;
  assign conv_en = pg_line;
endmodule

//--- sim/pdcs_tb.sv
`timescale 1ns/1ps
module testbench;
  localparam Q = 20;
  logic clk_sys = 0, rst_n = 0, above_class_low = 0;
  logic undervoltage_lockout = 1, uv_turn_on = 0, inrush_limit_program_active = 0;
  logic inrush_settled = 0, vsw_above_10v = 0, over_temp = 0;
  wire  switch_on_r, inrush_limit_program_r, class_sink_en_r, pg_line;
  wire  detection_sink_r, power_good_flag_oe_n_r, power_good_flag_o_r, conv_en;
  int   errors = 0, tests_run = 0;
  always #20 clk_sys = ~clk_sys;
  pdcs_sequencer #(.QUAL_CYC(Q)) pdcs_sequencer_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .above_class_low(above_class_low), .uv_turn_on(uv_turn_on),
    .undervoltage_lockout(undervoltage_lockout), .inrush_limit_program_active(inrush_limit_program_active),
    .inrush_settled(inrush_settled), .vsw_above_10v(vsw_above_10v),
    .over_temp(over_temp), .switch_on_r(switch_on_r),
    .inrush_limit_program_r(inrush_limit_program_r),
    .class_sink_en_r(class_sink_en_r), .detection_sink_r(detection_sink_r),
    .power_good_flag_oe_n_r(power_good_flag_oe_n_r),
    .power_good_flag_o_r(power_good_flag_o_r));
  pdcs_far_model pdcs_far_model_inst (.pg_line(pg_line), .conv_en(conv_en),
    .power_good_flag_oe_n_r(power_good_flag_oe_n_r),
    .power_good_flag_o_r(power_good_flag_o_r));
  // -----------------
  // Helpers
  // -----------------
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task chk(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask
  task print_verdict;
    $display("Counts: %0d checks, %0d errors", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait on switch (s=0) or limit select (s=1)
  task wt(input int s, input logic v);
    int i;
    for (i = 0; i < 200; i++) begin
      if ((s ? inrush_limit_program_r : switch_on_r) === v) break;
      cyc(1);
    end
    if (i == 200) begin
      errors++;
      $display("CHECK FAILED wait %0d expected %b seen timeout", s, v);
      print_verdict();
    end
  endtask
  // -----------------
  // Scenarios
  // -----------------
  task t_start;
    above_class_low = 1;
    cyc(12);
    chk("detect_sink", 0, detection_sink_r);
    chk("class_idle", 1, class_sink_en_r);
    chk("pg_drive", 0, power_good_flag_o_r);
    undervoltage_lockout = 0;
    uv_turn_on = 1;
    wt(0, 1);
    chk("inrush", 1, inrush_limit_program_r);
    chk("pg", 0, pg_line);
    inrush_settled = 1;
    cyc(Q - 5);
    inrush_settled = 0;
    cyc(10);
    inrush_settled = 1;
    cyc(Q - 5);
    chk("inrush_restart", 1, inrush_limit_program_r);
    wt(1, 0);
    chk("pg", 1, pg_line);
    chk("conv_en", 1, conv_en);
    $display("t_start done");
  endtask
  task t_over;
    inrush_limit_program_active = 1;
    cyc(Q + 20);
    chk("soft", 0, inrush_limit_program_r);
    vsw_above_10v = 1;
    cyc(10);
    chk("pg_hv", 0, pg_line);
    chk("hv_still_run", 0, inrush_limit_program_r);
    wt(1, 1);
    chk("pg", 0, pg_line);
    inrush_limit_program_active = 0;
    vsw_above_10v = 0;
    wt(1, 0);
    $display("t_over done");
  endtask
  task t_hot;
    over_temp = 1;
    wt(0, 0);
    chk("pg", 0, pg_line);
    chk("class_sink", 0, class_sink_en_r);
    over_temp = 0;
    wt(0, 1);
    chk("inrush", 0, inrush_limit_program_r);
    cyc(2);
    chk("pg", 1, pg_line);
    over_temp = 1;
    vsw_above_10v = 1;
    wt(0, 0);
    over_temp = 0;
    wt(0, 1);
    chk("inrush", 1, inrush_limit_program_r);
    chk("pg", 0, pg_line);
    vsw_above_10v = 0;
    wt(1, 0);
    $display("t_hot done");
  endtask
  task t_lock;
    undervoltage_lockout = 1;
    uv_turn_on = 0;
    wt(0, 0);
    chk("inrush", 1, inrush_limit_program_r);
    chk("pg", 1, pg_line);
    above_class_low = 0;
    cyc(12);
    chk("detect_sink", 1, detection_sink_r);
    $display("t_lock done");
  endtask
  initial begin
    cyc(10);
    rst_n = 1;
    cyc(2);
    t_start();
    t_over();
    t_hot();
    t_lock();
    print_verdict();
  end
endmodule
bind pdcs_sequencer pdcs_monitor #(.QUAL_CYC(QUAL_CYC)) mon_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .above_class_low(above_class_low),
  .undervoltage_lockout(undervoltage_lockout), .inrush_limit_program_active(inrush_limit_program_active),
  .inrush_settled(inrush_settled), .vsw_above_10v(vsw_above_10v),
  .over_temp(over_temp), .switch_on_r(switch_on_r),
  .inrush_limit_program_r(inrush_limit_program_r),
  .class_sink_en_r(class_sink_en_r), .detection_sink_r(detection_sink_r),
  .power_good_flag_oe_n_r(power_good_flag_oe_n_r),
  .power_good_flag_o_r(power_good_flag_o_r));
